/* design/onoff_ctrl_pkg.sv */
// Purpose : shared constants and types of the power on/off, fault clear and phase block
// Assumes : one 25 MHz clock, command bytes already decoded by the bus target engine
// Notes   : all offsets, fields, reset values and counts live here
package onoff_ctrl_pkg;

    // ==========
    // command codes
    localparam logic [7:0] CODE_ENABLE_CFG  = 8'h02;
    localparam logic [7:0] CODE_FAULT_CLEAR = 8'h03;
    localparam logic [7:0] CODE_PHASE_SEL   = 8'h04;

    // ==========
    // enable-source configuration fields
    localparam int         CFG_AUTOSTART_BIT = 4;
    localparam int         CFG_CMD_SEL_BIT   = 3;
    localparam int         CFG_PIN_SEL_BIT   = 2;
    localparam int         CFG_POLARITY_BIT  = 1;
    localparam int         CFG_OFF_DELAY_BIT = 0;
    localparam logic [7:0] CFG_UNUSED_MASK   = 8'he0;
    localparam logic [7:0] CFG_RESET         = 8'h17;

    // ==========
    // operation byte fields
    localparam int         OP_ON_BIT       = 7;
    localparam int         OP_SOFT_OFF_BIT = 6;

    // ==========
    // phase selection
    localparam int         NUM_PHASES  = 4;
    localparam logic [7:0] PHASE_ALL   = 8'hff;
    localparam logic [7:0] PHASE_RESET = 8'hff;
    localparam logic [7:0] PHASE_LEAD  = 8'h00;

    // ==========
    // status: bit that flags a rejected data byte
    localparam int         STATUS_W    = 8;
    localparam int         INVALID_BIT = 1;

    // ==========
    // converter sequencing
    localparam int         CNT_W = 16;

    typedef enum logic [1:0] {
        CONV_OFF  = 2'b00,
        CONV_ON   = 2'b01,
        CONV_HOLD = 2'b10,
        CONV_RAMP = 2'b11
    } conv_state_t;

    typedef struct packed {
        logic       valid;
        logic       write;
        logic [7:0] code;
        logic [7:0] data;
    } cmd_req_t;

    typedef struct packed {
        logic       valid;
        logic       ack;
        logic       invalid;
        logic [7:0] data;
    } cmd_resp_t;

endpackage : onoff_ctrl_pkg

/* design/level_sync.sv */
// Purpose : two-flop synchroniser for levels arriving from pins
// Assumes : inputs are quasi-static compared with the clock
// Notes   : first stage is read only by the second stage
`timescale 1ns/1ps
module level_sync #(
    parameter int W = 1
) (
    input  wire logic         sys_clk_i,
    input  wire logic         rstn_i,
    input  wire logic [W-1:0] async_i,
    output logic      [W-1:0] sync_o
);
    logic [W-1:0] meta_r;

    always_ff @(posedge sys_clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            meta_r <= '0;
            sync_o <= '0;
        end
        else
        begin
            meta_r <= async_i;
            sync_o <= meta_r;
        end
    end
endmodule : level_sync

/* design/power_onoff_ctrl.sv */
// Purpose : start/stop decision, fault status clear with alert handling, phase selection
// Assumes : command bytes arrive decoded; alert response success is a one-cycle pulse
// Notes   : alert pin is open drain, the wire is pulled low while alert_oe_o is high
//
// Behaviour
// - upper three enable-config bits read zero; a write setting any of them is rejected.
// - autostart clear means run whenever input power is present.
// - command-select bit decides whether the operation on/off bit counts.
// - pin-select bit decides whether the enable pin counts; lockout follows it.
// - both select bits set means pin and command must both agree.
// - polarity bit 0 is active-low pin, 1 active-high; lockout needs high.
// - delay bit 0, pin off: hold regulation, then ramp output down.
// - delay bit 1, pin off: stop conversion immediately.
// - the enable/undervoltage pin is the enable pin used here.
// - unsupported enable-config value is rejected, flagged and alerted.
// - fault clear wipes status of selected phase, or all phases on all-select.
// - fault clear also releases the alert output.
// - fault clear never restarts a converter latched off by a fault.
// - a fault still present after clearing sets its bit again and alerts.
// - after alert response reply, release alert but keep status bits.
// - sources seen before the reply stay muted until cleared or the converter restarts; newer ones alert.
// - written phase selects the target of later phased commands.
// - phased commands fail until the phase configuration exists.
// - each phase keeps its own status storage selected by phase.
// - lead device is phase zero; followers take their stack position.
// - phases below phase_count_i single, all-select means every phase, others invalid.
// - operation bit 7 off stops, on enables when command input counts.
`timescale 1ns/1ps
module power_onoff_ctrl
    import onoff_ctrl_pkg::*;
#(
    parameter int PHASES = onoff_ctrl_pkg::NUM_PHASES
) (
    input  wire logic                                 sys_clk_i,
    input  wire logic                                 rstn_i,
    // decoded command port
    input  wire onoff_ctrl_pkg::cmd_req_t             cmd_i,
    output onoff_ctrl_pkg::cmd_resp_t                 resp_o,
    input  wire logic                                 ara_done_i,
    // pins
    input  wire logic                                 enable_undervoltage_pin_i,
    input  wire logic                                 sense_follower_select_pin_i,
    // same-domain inputs from the rest of the device
    input  wire logic                                 input_power_ok_i,
    input  wire logic [7:0]                           operation_i,
    input  wire logic                                 fault_latched_off_i,
    input  wire logic [PHASES-1:0][STATUS_W-1:0]      fault_src_i,
    input  wire logic [1:0]                           stack_position_i,
    input  wire logic [2:0]                           phase_count_i,
    input  wire logic                                 phase_cfg_ready_i,
    input  wire logic [onoff_ctrl_pkg::CNT_W-1:0]     turnoff_hold_cycles_i,
    input  wire logic [onoff_ctrl_pkg::CNT_W-1:0]     turnoff_ramp_cycles_i,
    // outputs
    output logic                                      convert_en_o,
    output logic                                      ramp_down_o,
    output logic                                      undervoltage_lockout_en_o,
    output logic                                      alert_oe_o,
    output logic [7:0]                                phase_sel_o,
    output logic [7:0]                                own_phase_o,
    output logic [PHASES-1:0][STATUS_W-1:0]           status_o
);
    import onoff_ctrl_pkg::*;

    // ==========
    // state
    typedef struct packed {
        conv_state_t                      conv;
        logic [CNT_W-1:0]                 cnt;
        logic [7:0]                       cfg;
        logic [7:0]                       phase_sel;
        logic [7:0]                       own_phase;
        logic [PHASES-1:0][STATUS_W-1:0]  status;
        logic [PHASES-1:0][STATUS_W-1:0]  muted;
        logic                             alert;
        logic                             undervoltage_lockout_en;
        cmd_resp_t                        resp;
    } ctrl_state_t;

    ctrl_state_t s_r;
    ctrl_state_t s_nxt;

    // ==========
    // pin synchronisers
    logic [1:0] pins_sync;

    level_sync #(
        .W (2)
    ) u_pin_sync (
        .sys_clk_i (sys_clk_i),
        .rstn_i    (rstn_i),
        .async_i   ({sense_follower_select_pin_i, enable_undervoltage_pin_i}),
        .sync_o    (pins_sync)
    );

    logic en_pin_s;
    logic follower_s;
    assign en_pin_s   = pins_sync[0];
    assign follower_s = pins_sync[1];

    // ==========
    // next state
    logic                            pin_active;
    logic                            pin_gate;
    logic                            cmd_gate;
    logic                            run_req;
    logic                            pin_off_event;
    logic                            cmd_off_event;
    logic                            invalid_set;
    logic                            clear_hit;
    logic                            any_new;
    logic                            clear_any;
    logic                            off_on_toggle;
    logic [STATUS_W-1:0]             set_bits;
    logic [STATUS_W-1:0]             base_bits;
    logic [STATUS_W-1:0]             base_muted;
    logic [7:0]                      phase_limit;

    always_comb
    begin
        s_nxt         = s_r;
        invalid_set   = 1'b0;
        clear_hit     = 1'b0;
        any_new       = 1'b0;
        clear_any     = 1'b0;
        off_on_toggle = 1'b0;
        set_bits      = '0;
        base_bits     = '0;
        base_muted    = '0;
        phase_limit   = {5'h00, phase_count_i};

        s_nxt.resp = '0;

        // own phase from strap pin; lead is fixed at zero
        s_nxt.own_phase = follower_s ? {6'h00, stack_position_i} : PHASE_LEAD;

        // polarity applied after the synchroniser
        pin_active = s_r.cfg[CFG_POLARITY_BIT] ? en_pin_s : ~en_pin_s;
        pin_gate   = s_r.cfg[CFG_PIN_SEL_BIT] ? pin_active : 1'b1;
        cmd_gate   = s_r.cfg[CFG_CMD_SEL_BIT] ? operation_i[OP_ON_BIT] : 1'b1;

        // lockout function only with the pin respected and active high
        s_nxt.undervoltage_lockout_en = s_r.cfg[CFG_PIN_SEL_BIT] & s_r.cfg[CFG_POLARITY_BIT];

        if (!s_r.cfg[CFG_AUTOSTART_BIT])
        begin
            run_req = input_power_ok_i;
        end
        else
        begin
            run_req = input_power_ok_i & pin_gate & cmd_gate;
        end
        // a latched-off fault keeps the converter down whatever clears status
        run_req = run_req & ~fault_latched_off_i;

        pin_off_event = s_r.cfg[CFG_PIN_SEL_BIT] & ~pin_active;
        cmd_off_event = s_r.cfg[CFG_CMD_SEL_BIT] & ~operation_i[OP_ON_BIT];

        // ==========
        // command handling
        if (cmd_i.valid)
        begin
            s_nxt.resp.valid = 1'b1;
            s_nxt.resp.ack   = 1'b1;
            unique case (cmd_i.code)
                CODE_ENABLE_CFG:
                begin
                    if (cmd_i.write)
                    begin
                        if ((cmd_i.data & CFG_UNUSED_MASK) != 8'h00)
                        begin
                            invalid_set        = 1'b1;
                            s_nxt.resp.invalid = 1'b1;
                        end
                        else
                        begin
                            s_nxt.cfg = cmd_i.data;
                        end
                    end
                    else
                    begin
                        s_nxt.resp.data = s_r.cfg & ~CFG_UNUSED_MASK;
                    end
                end
                CODE_FAULT_CLEAR:
                begin
                    if (!cmd_i.write)
                    begin
                        s_nxt.resp.ack = 1'b0;
                    end
                    else if (!phase_cfg_ready_i)
                    begin
                        invalid_set        = 1'b1;
                        s_nxt.resp.invalid = 1'b1;
                    end
                    else
                    begin
                        clear_hit = 1'b1;
                    end
                end
                CODE_PHASE_SEL:
                begin
                    if (cmd_i.write)
                    begin
                        // valid: single phase present in the stack, or all-select
                        if (cmd_i.data == PHASE_ALL ||
                            (phase_cfg_ready_i && cmd_i.data < phase_limit))
                        begin
                            s_nxt.phase_sel = cmd_i.data;
                        end
                        else
                        begin
                            invalid_set        = 1'b1;
                            s_nxt.resp.invalid = 1'b1;
                        end
                    end
                    else
                    begin
                        s_nxt.resp.data = s_r.phase_sel;
                    end
                end
                default:
                begin
                    s_nxt.resp.ack = 1'b0;
                end
            endcase
        end

        // ==========
        // converter sequencing
        s_nxt.cnt = (s_r.cnt != '0) ? s_r.cnt - CNT_W'(1) : '0;
        unique case (s_r.conv)
            CONV_OFF:
            begin
                if (run_req)
                begin
                    s_nxt.conv    = CONV_ON;
                    off_on_toggle = 1'b1;
                end
            end
            CONV_ON:
            begin
                if (fault_latched_off_i)
                begin
                    s_nxt.conv = CONV_OFF;
                end
                else if (!run_req)
                begin
                    if (pin_off_event && s_r.cfg[CFG_OFF_DELAY_BIT])
                    begin
                        s_nxt.conv = CONV_OFF;
                    end
                    else if ((pin_off_event && !s_r.cfg[CFG_OFF_DELAY_BIT]) ||
                             (cmd_off_event && operation_i[OP_SOFT_OFF_BIT]))
                    begin
                        s_nxt.conv = CONV_HOLD;
                        s_nxt.cnt  = turnoff_hold_cycles_i;
                    end
                    else
                    begin
                        s_nxt.conv = CONV_OFF;
                    end
                end
            end
            CONV_HOLD:
            begin
                if (fault_latched_off_i)
                begin
                    s_nxt.conv = CONV_OFF;
                end
                else if (pin_off_event && s_r.cfg[CFG_OFF_DELAY_BIT])
                begin
                    s_nxt.conv = CONV_OFF;
                end
                else if (run_req)
                begin
                    s_nxt.conv = CONV_ON;
                end
                else if (s_r.cnt == '0)
                begin
                    s_nxt.conv = CONV_RAMP;
                    s_nxt.cnt  = turnoff_ramp_cycles_i;
                end
            end
            CONV_RAMP:
            begin
                // ramp runs to zero unless a latched-off fault stops it; a restart waits for zero output
                if (fault_latched_off_i || s_r.cnt == '0)
                begin
                    s_nxt.conv = CONV_OFF;
                end
            end
        endcase

        // ==========
        // status and alert, per phase
        for (int p = 0; p < PHASES; p++)
        begin
            set_bits = fault_src_i[p];
            if (invalid_set && s_r.own_phase == 8'(p))
            begin
                set_bits[INVALID_BIT] = 1'b1;
            end
            if (clear_hit && (s_r.phase_sel == PHASE_ALL || s_r.phase_sel == 8'(p)))
            begin
                base_bits  = '0;
                base_muted = '0;
                clear_any  = 1'b1;
            end
            else
            begin
                base_bits  = s_r.status[p];
                base_muted = off_on_toggle ? '0 : s_r.muted[p];
            end
            // set wins over clear so a standing fault is not lost
            s_nxt.status[p] = base_bits | set_bits;
            if ((set_bits & ~base_bits & ~base_muted) != '0)
            begin
                any_new = 1'b1;
            end
            s_nxt.muted[p] = ara_done_i ? (base_muted | s_nxt.status[p]) : base_muted;
        end

        if (any_new)
        begin
            s_nxt.alert = 1'b1;
        end
        else if (clear_any)
        begin
            s_nxt.alert = 1'b0;
        end
        else if (ara_done_i)
        begin
            s_nxt.alert = 1'b0;
        end
    end

    // ==========
    // registers
    always_ff @(posedge sys_clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            s_r           <= '0;
            s_r.conv      <= CONV_OFF;
            s_r.cfg       <= CFG_RESET;
            s_r.phase_sel <= PHASE_RESET;
            s_r.own_phase <= PHASE_LEAD;
        end
        else
        begin
            s_r <= s_nxt;
        end
    end

    // ==========
    // outputs straight from state flops
    assign convert_en_o              = (s_r.conv != CONV_OFF);
    assign ramp_down_o               = (s_r.conv == CONV_RAMP);
    assign undervoltage_lockout_en_o = s_r.undervoltage_lockout_en;
    assign alert_oe_o                = s_r.alert;
    assign phase_sel_o               = s_r.phase_sel;
    assign own_phase_o               = s_r.own_phase;
    assign status_o                  = s_r.status;
    assign resp_o                    = s_r.resp;

endmodule : power_onoff_ctrl

/* tb/onoff_props.sv */
// Purpose : port-level checks of the on/off, fault clear and phase block
// Assumes : one clock domain, asynchronous active-low reset
// Notes   : bound in below
`timescale 1ns/1ps
module onoff_props #(
    parameter int PHASES = onoff_ctrl_pkg::NUM_PHASES
) (
    input wire logic                      sys_clk_i,
    input wire logic                      rstn_i,
    input wire onoff_ctrl_pkg::cmd_req_t  cmd_i,
    input wire onoff_ctrl_pkg::cmd_resp_t resp_o,
    input wire logic                      ara_done_i,
    input wire logic                      sense_follower_select_pin_i,
    input wire logic [PHASES-1:0][onoff_ctrl_pkg::STATUS_W-1:0] fault_src_i,
    input wire logic                      fault_latched_off_i,
    input wire logic [1:0]                stack_position_i,
    input wire logic                      phase_cfg_ready_i,
    input wire logic                      convert_en_o,
    input wire logic                      ramp_down_o,
    input wire logic                      undervoltage_lockout_en_o,
    input wire logic                      alert_oe_o,
    input wire logic [7:0]                phase_sel_o,
    input wire logic [7:0]                own_phase_o,
    input wire logic [PHASES-1:0][onoff_ctrl_pkg::STATUS_W-1:0] status_o
);
    import onoff_ctrl_pkg::*;
    // ==========
    // clocking
    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (!rstn_i);
    // ==========
    // command port
    cfg_write_ack_a: assert property (
        cmd_i.valid && cmd_i.write && cmd_i.code == CODE_ENABLE_CFG && cmd_i.data[7:5] == 3'h0
        |=> resp_o.valid && resp_o.ack && !resp_o.invalid) else $error("config write refused");
    cfg_upper_a: assert property (
        resp_o.valid && $past(cmd_i.valid && !cmd_i.write && cmd_i.code == CODE_ENABLE_CFG)
        |-> resp_o.data[7:5] == 3'h0) else $error("config upper bits not zero");
    cfg_bad_a: assert property (
        cmd_i.valid && cmd_i.write && cmd_i.code == CODE_ENABLE_CFG && cmd_i.data[7:5] != 3'h0
        |=> resp_o.invalid ##[0:1] status_o[own_phase_o[1:0]][INVALID_BIT])
        else $error("bad config not flagged");
    lockout_en_a: assert property (
        resp_o.valid && resp_o.ack && !resp_o.invalid
        && $past(cmd_i.write && cmd_i.code == CODE_ENABLE_CFG)
        |-> ##1 undervoltage_lockout_en_o == $past(cmd_i.data[2] && cmd_i.data[1], 2))
        else $error("lockout enable wrong");
    phase_bad_a: assert property (
        cmd_i.valid && cmd_i.write && cmd_i.code == CODE_PHASE_SEL
        && cmd_i.data > 8'h03 && cmd_i.data < 8'hff
        |=> resp_o.invalid && $stable(phase_sel_o)) else $error("bad phase accepted");
    // ==========
    // converter
    latch_off_a: assert property (
        fault_latched_off_i |=> !convert_en_o) else $error("runs while latched off");
    ramp_on_a: assert property (
        ramp_down_o |-> convert_en_o) else $error("ramp without conversion");
    // ==========
    // alert and phase identity
    ara_keep_a: assert property (
        ara_done_i && !cmd_i.valid && $stable(fault_src_i) && $stable(status_o)
        |=> !alert_oe_o && $stable(status_o)) else $error("alert response mishandled");
    clear_alert_a: assert property (
        cmd_i.valid && cmd_i.write && cmd_i.code == CODE_FAULT_CLEAR && phase_cfg_ready_i
        && fault_src_i == '0 && $stable(status_o) |=> !alert_oe_o) else $error("alert kept");
    lead_phase_a: assert property (
        (!sense_follower_select_pin_i)[*4] |-> own_phase_o == PHASE_LEAD)
        else $error("lead phase wrong");
    follow_phase_a: assert property (
        (sense_follower_select_pin_i && $stable(stack_position_i))[*4]
        |-> own_phase_o == {6'h00, stack_position_i}) else $error("follower phase wrong");
endmodule : onoff_props

bind power_onoff_ctrl onoff_props #(.PHASES(PHASES)) props_u (.*);

/* tb/host_model.sv */
// Purpose : bus host and enable pin driver facing the block
// Assumes : one command at a time, answer one cycle after it is taken
// Notes   : released command fields are inverted so stale data never looks valid
`timescale 1ns/1ps
module host_model (
    input  wire logic                      sys_clk_i,
    input  wire onoff_ctrl_pkg::cmd_resp_t resp_i,
    output onoff_ctrl_pkg::cmd_req_t       cmd_o,
    output logic                           ara_done_o,
    output logic                           pin_o
);
    import onoff_ctrl_pkg::*;
    cmd_resp_t got;
    initial
    begin
        cmd_o = '0;
        ara_done_o = 1'b0;
        pin_o = 1'b1;
    end
    // ==========
    // transfers
    task xfer(input logic w, input logic [7:0] c, input logic [7:0] d);
        @(posedge sys_clk_i) cmd_o <= '{valid: 1'b1, write: w, code: c, data: d};
        @(posedge sys_clk_i) cmd_o <= '{valid: 1'b0, write: ~w, code: ~c, data: ~d};
        #1 got = resp_i;
    endtask : xfer
    task ara;
        @(posedge sys_clk_i) ara_done_o <= 1'b1;
        @(posedge sys_clk_i) ara_done_o <= 1'b0;
    endtask : ara
    task set_pin(input logic v);
        @(posedge sys_clk_i) pin_o <= v;
    endtask : set_pin
endmodule : host_model

/* tb/power_onoff_fault_clear_phase_select_tb.sv */
// Purpose : self-checking bench of the on/off, fault clear and phase block
// Assumes : 25 MHz clock, short hold and ramp counts
// Notes   : reset and identity checks first, then start/stop table, then hand-written cases
`timescale 1ns/1ps
module power_onoff_fault_clear_phase_select_tb;
    import onoff_ctrl_pkg::*;
    typedef struct packed {
        logic [7:0] cfg;
        logic       pin;
        logic [7:0] op;
        logic       conv;
        logic       undervoltage_lockout;
    } row_t;
    // ==========
    // signals
    logic            sys_clk_i = 1'b0;
    logic            pwr = 1'b1;
    logic [15:0]     hold = 16'h0003;
    logic [15:0]     ramp = 16'h0002;
    logic            rstn_i = 1'b0;
    cmd_req_t        cmd;
    cmd_resp_t       resp;
    logic            ara, pin, conv, rdn, undervoltage_lockout, alert, seen;
    logic            sense = 1'b0;
    logic            latch = 1'b0;
    logic            ready = 1'b0;
    logic [7:0]      op = 8'h00;
    logic [1:0]      stack = 2'h0;
    logic [2:0]      cnt = 3'h4;
    logic [3:0][7:0] src = '0;
    logic [3:0][7:0] stat;
    logic [7:0]      psel, own;
    int              n_errors = 0;
    int              n_checks = 0;
    int              n;
    row_t            rows [8] = '{'{8'h00, 1'b1, 8'h00, 1'b1, 1'b0},
        '{8'h1d, 1'b1, 8'h80, 1'b0, 1'b0}, '{8'h1d, 1'b0, 8'h80, 1'b1, 1'b0},
        '{8'h1d, 1'b0, 8'h00, 1'b0, 1'b0}, '{8'h1f, 1'b1, 8'h80, 1'b1, 1'b1},
        '{8'h17, 1'b1, 8'h00, 1'b1, 1'b1}, '{8'h1b, 1'b0, 8'h80, 1'b1, 1'b0},
        '{8'h1b, 1'b0, 8'h00, 1'b0, 1'b0}};
    always #20 sys_clk_i = ~sys_clk_i;
    host_model host_u (.sys_clk_i, .resp_i(resp), .cmd_o(cmd), .ara_done_o(ara), .pin_o(pin));
    power_onoff_ctrl #(.PHASES(4)) dut_u (.sys_clk_i, .rstn_i, .cmd_i(cmd), .resp_o(resp),
        .ara_done_i(ara), .enable_undervoltage_pin_i(pin), .sense_follower_select_pin_i(sense),
        .input_power_ok_i(pwr), .operation_i(op), .fault_latched_off_i(latch),
        .fault_src_i(src), .stack_position_i(stack), .phase_count_i(cnt),
        .phase_cfg_ready_i(ready), .turnoff_hold_cycles_i(hold), .turnoff_ramp_cycles_i(ramp),
        .convert_en_o(conv), .ramp_down_o(rdn), .undervoltage_lockout_en_o(undervoltage_lockout),
        .alert_oe_o(alert), .phase_sel_o(psel), .own_phase_o(own), .status_o(stat));
    // ==========
    // helpers
    task wr(input logic [7:0] c, input logic [7:0] d);
        host_u.xfer(1'b1, c, d);
    endtask : wr
    task rd(input logic [7:0] c);
        host_u.xfer(1'b0, c, 8'h00);
    endtask : rd
    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            n_errors++;
            $display("wrong value at %0t: got %h want %h", $time, got, exp);
        end
    endtask : chk
    task tick(input int k);
        repeat (k) @(posedge sys_clk_i);
        #1;
    endtask : tick
    task wrap_up;
        $display("checks %0d mismatches %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : wrap_up
    task wait_conv(input logic v);
        for (int k = 0; k < 40 && conv !== v; k++)
            tick(1);
        chk(conv, v);
        if (conv !== v)
            wrap_up();
    endtask : wait_conv
    // ==========
    // main sequence
    initial
    begin
        repeat (4) @(posedge sys_clk_i);
        chk({psel, own, 7'h00, alert}, {PHASE_RESET, PHASE_LEAD, 8'h00});
        chk(stat, 32'h0);
        rstn_i <= 1'b1;
        rd(CODE_ENABLE_CFG);
        chk(host_u.got.data, CFG_RESET);
        @(posedge sys_clk_i) sense <= 1'b1;
        stack <= 2'h2;
        tick(5);
        chk(own, 8'h02);
        @(posedge sys_clk_i) sense <= 1'b0;
        tick(5);
        chk(own, 8'h00);
        $display("reset and identity done");
        foreach (rows[r])
        begin
            host_u.set_pin(rows[r].pin);
            op <= rows[r].op;
            wr(CODE_ENABLE_CFG, rows[r].cfg);
            tick(5);
            chk({conv, undervoltage_lockout}, {rows[r].conv, rows[r].undervoltage_lockout});
            rd(CODE_ENABLE_CFG);
            chk(host_u.got.data, rows[r].cfg);
        end
        wr(CODE_ENABLE_CFG, 8'h00);
        @(posedge sys_clk_i) pwr <= 1'b0;
        tick(2);
        chk(conv, 1'b0);
        pwr <= 1'b1;
        $display("start/stop table done");
        wr(CODE_ENABLE_CFG, 8'h1c);
        op <= 8'h80;
        ramp <= 16'h0004;
        host_u.set_pin(1'b0);
        wait_conv(1'b1);
        host_u.set_pin(1'b1);
        for (n = 0; n < 20 && rdn !== 1'b1; n++)
            tick(1);
        for (n = 0; n < 20 && rdn === 1'b1; n++)
            tick(1);
        chk(n, 5);
        chk(conv, 1'b0);
        wr(CODE_ENABLE_CFG, 8'h1d);
        host_u.set_pin(1'b0);
        wait_conv(1'b1);
        host_u.set_pin(1'b1);
        seen = 1'b0;
        repeat (6)
        begin
            tick(1);
            seen = seen | rdn;
        end
        chk({conv, seen}, 2'b00);
        $display("turn-off profiles done");
        wr(CODE_PHASE_SEL, 8'h01);
        chk(host_u.got.invalid, 1'b1);
        @(posedge sys_clk_i) ready <= 1'b1;
        wr(CODE_PHASE_SEL, 8'h03);
        rd(CODE_PHASE_SEL);
        chk(host_u.got.data, 8'h03);
        wr(CODE_PHASE_SEL, 8'h05);
        chk(host_u.got.invalid, 1'b1);
        @(posedge sys_clk_i) cnt <= 3'h2;
        wr(CODE_PHASE_SEL, 8'h03);
        chk(host_u.got.invalid, 1'b1);
        @(posedge sys_clk_i) cnt <= 3'h4;
        wr(CODE_ENABLE_CFG, 8'hf7);
        chk(host_u.got.invalid, 1'b1);
        rd(CODE_ENABLE_CFG);
        chk(host_u.got.data, 8'h1d);
        tick(2);
        chk({stat[0][INVALID_BIT], alert}, 2'b11);
        $display("refusals done");
        wr(CODE_PHASE_SEL, PHASE_ALL);
        wr(CODE_FAULT_CLEAR, 8'h00);
        tick(2);
        chk({stat, 7'h00, alert}, 40'h0);
        @(posedge sys_clk_i) src[1][4] <= 1'b1;
        tick(3);
        chk(alert, 1'b1);
        host_u.ara();
        tick(1);
        chk({stat[1], 7'h00, alert}, 16'h1000);
        tick(3);
        chk(alert, 1'b0);
        @(posedge sys_clk_i) src[2][5] <= 1'b1;
        tick(3);
        chk(alert, 1'b1);
        wr(CODE_PHASE_SEL, 8'h01);
        wr(CODE_FAULT_CLEAR, 8'h00);
        tick(2);
        chk({stat[2], stat[1], 7'h00, alert}, 24'h201001);
        $display("fault clear and alert done");
        host_u.set_pin(1'b0);
        wait_conv(1'b1);
        @(posedge sys_clk_i) latch <= 1'b1;
        tick(2);
        chk(conv, 1'b0);
        wr(CODE_FAULT_CLEAR, 8'h00);
        tick(3);
        chk(conv, 1'b0);
        $display("latched off done");
        wrap_up();
    end
endmodule : power_onoff_fault_clear_phase_select_tb
